// *** verification/tbbm_master_asserts.sv ***
// Concurrent checks on the serial bus master ports
`timescale 1ns/100ps
`include "tbbm_cfg.svh"
module tbbm_master_asserts #(
	parameter int DATA_W = 8,
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [`TBBM_ADDR_W-1:0] sfr_addr,
	input wire logic [DATA_W-1:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [DATA_W-1:0] sfr_rdata,
	input wire logic tick_400k,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic int6_irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	wire rd_csr = sfr_rd && sfr_addr == `TBBM_OFS_CSR;
	wire rd_int6 = sfr_rd && sfr_addr == `TBBM_OFS_INT6;
	wire rd_void = sfr_rd && sfr_addr == 16'hff86;
	wire go_wr = sfr_wr && sfr_addr == `TBBM_OFS_CSR && sfr_wdata[1];
	a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("line drive value not low");
	a_scl_high_min: assert property ($rose(scl_oe_n) |=> scl_oe_n [*4])
		else $error("clock high phase too short");
	a_rdata_hold: assert property (!$past(sfr_rd) && !$past(sfr_rd, 2) |-> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_void_read: assert property (rd_void |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_csr_spare: assert property (rd_csr |=> sfr_rdata[7:3] == 5'h00)
		else $error("control spare bits set");
	a_int6_spare: assert property (rd_int6 |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata[1:0] == 2'h0)
		else $error("interrupt spare bits set");
	a_irq_read_clr: assert property (rd_int6 && int6_irq |=> !int6_irq)
		else $error("interrupt kept after read");
	a_irq_start_clr: assert property (go_wr |=> !int6_irq)
		else $error("interrupt kept after start");
	a_irq_at_stop: assert property ($rose(int6_irq) |-> ##[0:2] (scl_oe_n && sda_oe_n))
		else $error("interrupt before bus release");
	a_start_scl: assert property ($fell(sda_oe_n) && scl_oe_n |-> ##[1:20] !scl_oe_n)
		else $error("no clock after start");
	cover property (go_wr);
	cover property ($rose(int6_irq));
	cover property (rd_void);
endmodule : tbbm_master_asserts
bind tbbm_master tbbm_master_asserts #(.DATA_W(DATA_W), .SYNC_STAGES(SYNC_STAGES)) u_chk (
	.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .tick_400k(tick_400k),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .int6_irq(int6_irq));

// *** verification/tbbm_master_bench.sv ***
// Testbench of the serial bus master with a slave on the bus
`timescale 1ns/100ps
`include "tbbm_cfg.svh"
module tbbm_master_bench;
	logic clk_sys, rstn, sfr_wr, sfr_rd, tick;
	logic [15:0] sfr_addr;
	logic [7:0] sfr_wdata, got;
	wire [7:0] sfr_rdata;
	wire scl_out, scl_oe_n, sda_out, sda_oe_n, int6_irq, sda_rel;
	wire scl = scl_oe_n ? 1'b1 : scl_out;
	wire sda = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;
	int mismatches = 0;
	int cmp_count = 0;
	localparam logic [6:0] SLV = 7'h52;
	tbbm_master DUT (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.tick_400k(tick), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int6_irq(int6_irq));
	tbbm_slave_model #(.ADDR(SLV)) u_slave (.scl(scl), .sda(sda), .sda_rel(sda_rel));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		tick = 1'b0;
		#3;
		forever #62.5 tick = ~tick;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic peek(input logic [15:0] a);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		@(posedge clk_sys);
		#1;
		got = sfr_rdata;
	endtask : peek
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		peek(a);
		chk(got, e);
	endtask : rd
	task automatic start(input logic [7:0] c, input logic [7:0] e);
		wr(`TBBM_OFS_CSR, c);
		rd(`TBBM_OFS_CSR, e);
	endtask : start
	task automatic finish;
		int n = 0;
		do
		begin
			peek(`TBBM_OFS_CSR);
			n++;
		end
		while (got[1] !== 1'b0 && n < 500);
		chk(got & 8'h02, 8'h00);
	endtask : finish
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#500000;
		mismatches++;
		$display("mismatch at %0t: timeout", $time);
		complete_run();
	end
	initial
	begin
		rstn = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 16'h0000;
		sfr_wdata = 8'h00;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int a = 16'hff80; a <= 16'hff86; a++)
			rd(a[15:0], 8'h00);
		rd(`TBBM_OFS_INT6, 8'h00);
		wr(`TBBM_OFS_INT6, 8'hff);
		rd(`TBBM_OFS_INT6, 8'h08);
		wr(16'hff86, 8'h77);
		rd(16'hff86, 8'h00);
		$display("test registers done");
		wr(`TBBM_OFS_TARGET, {SLV, 1'b0});
		wr(`TBBM_OFS_WR1, 8'ha5);
		wr(`TBBM_OFS_WR2, 8'h3c);
		rd(`TBBM_OFS_TARGET, {SLV, 1'b0});
		start(8'h03, 8'h03);
		wr(`TBBM_OFS_WR1, 8'h00);
		rd(`TBBM_OFS_WR1, 8'ha5);
		finish();
		chk({7'h00, int6_irq}, 8'h01);
		chk(u_slave.wr[0], 8'ha5);
		chk(u_slave.wr[1], 8'h3c);
		rd(`TBBM_OFS_INT6, 8'h0c);
		chk({7'h00, int6_irq}, 8'h00);
		rd(`TBBM_OFS_INT6, 8'h08);
		$display("test two byte write done");
		wr(`TBBM_OFS_TARGET, {SLV ^ 7'h01, 1'b0});
		start(8'h02, 8'h02);
		finish();
		rd(`TBBM_OFS_CSR, 8'h04);
		chk({7'h00, int6_irq}, 8'h01);
		$display("test missing acknowledge done");
		wr(`TBBM_OFS_TARGET, {SLV, 1'b0});
		wr(`TBBM_OFS_WR1, 8'h5a);
		start(8'h02, 8'h02);
		finish();
		rd(`TBBM_OFS_CSR, 8'h00);
		chk(u_slave.wr[0], 8'h5a);
		chk(u_slave.wr[1], 8'h3c);
		$display("test one byte write done");
		u_slave.rd[0] = 8'h96;
		u_slave.rd[1] = 8'h4b;
		wr(`TBBM_OFS_TARGET, {SLV, 1'b1});
		start(8'h02, 8'h02);
		chk({7'h00, int6_irq}, 8'h00);
		finish();
		rd(`TBBM_OFS_RD1, 8'h96);
		$display("test one byte read done");
		u_slave.rd[0] = 8'hc3;
		start(8'h03, 8'h03);
		finish();
		rd(`TBBM_OFS_RD1, 8'hc3);
		rd(`TBBM_OFS_RD2, 8'h4b);
		$display("test two byte read done");
		complete_run();
	end
endmodule : tbbm_master_bench

// *** verification/tbbm_slave_model.sv ***
// Behavioural two-wire slave that answers at one address
`timescale 1ns/100ps
module tbbm_slave_model #(
	parameter logic [6:0] ADDR = 7'h52
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_rel
);
	logic [7:0] sh;
	logic [7:0] wr [2];
	logic [7:0] rd [2];
	int k;
	int b;
	bit act;
	bit go;
	bit rdm;
	initial
	begin
		sda_rel = 1'b1;
		act = 1'b0;
	end
	// Start and stop are judged after both lines settle
	always @(negedge sda)
	begin
		#1;
		if (scl)
		begin
			k = 0;
			b = 0;
			act = 1'b1;
		end
	end
	always @(posedge sda)
	begin
		#1;
		if (scl)
			act = 1'b0;
	end
	always @(posedge scl)
		if (act)
		begin
			if (k < 8)
				sh = {sh[6:0], sda};
			if (k == 7 && b == 0)
			begin
				rdm = sh[0];
				go = sh[7:1] == ADDR;
			end
			else if (k == 7 && !rdm && b < 3)
				wr[b-1] = sh;
			if (k == 8 && rdm && b > 0 && sda)
				go = 1'b0;
			k = (k == 8) ? 0 : k + 1;
			if (k == 0)
				b++;
		end
	always @(negedge scl)
	begin
		sda_rel = 1'b1;
		if (act && go && k == 8 && (b == 0 || !rdm))
			sda_rel = 1'b0;
		else if (act && go && rdm && b > 0 && b < 3 && k < 8)
			sda_rel = rd[b-1][7-k];
	end
endmodule : tbbm_slave_model

// *** verilog/tbbm_bit_engine.sv ***
// Line engine: one bus symbol per command, two half periods of the bit tick each
`timescale 1ns/100ps
module tbbm_bit_engine (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic half_edge,
	input wire logic sda_level,
	tbbm_bit_if.engine bus,
	output logic scl_release,
	output logic sda_release
);
	logic busy;
	logic phase;
	tbbm_pkg::tbbm_cmd_t kind;
	logic rx;
	logic done_pulse;

	wire accept = bus.valid && !busy;
	wire first_half_end = busy && half_edge && !phase;
	wire second_half_end = busy && half_edge && phase;
	wire is_start = kind == tbbm_pkg::TBBM_CMD_START;
	wire is_stop = kind == tbbm_pkg::TBBM_CMD_STOP;
	wire acc_start = bus.cmd == tbbm_pkg::TBBM_CMD_START;
	wire acc_sda = (bus.cmd == tbbm_pkg::TBBM_CMD_WBIT) ? bus.tx_bit
		: (bus.cmd == tbbm_pkg::TBBM_CMD_RBIT);

	assign bus.ready = !busy;
	assign bus.done = done_pulse;
	assign bus.rx_bit = rx;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			busy <= 1'b0;
			phase <= 1'b0;
			kind <= tbbm_pkg::TBBM_CMD_STOP;
			rx <= 1'b1;
			done_pulse <= 1'b0;
			scl_release <= 1'b1;
			sda_release <= 1'b1;
		end
		else
		begin
			done_pulse <= second_half_end;
			if (accept)
			begin
				// First half: clock low for data and stop, both lines high for start
				busy <= 1'b1;
				phase <= 1'b0;
				kind <= bus.cmd;
				scl_release <= acc_start;
				sda_release <= acc_start ? 1'b1 : acc_sda;
			end
			else if (first_half_end)
			begin
				phase <= 1'b1;
				scl_release <= 1'b1;
				if (is_start)
					sda_release <= 1'b0;
			end
			else if (second_half_end)
			begin
				busy <= 1'b0;
				rx <= sda_level;
				if (is_stop)
					sda_release <= 1'b1;
			end
		end
	end
endmodule : tbbm_bit_engine

// *** verilog/tbbm_bit_if.sv ***
// Bit-level command channel between the transaction sequencer and the line engine
`timescale 1ns/100ps
interface tbbm_bit_if;
	tbbm_pkg::tbbm_cmd_t cmd;
	logic tx_bit;
	logic valid;
	logic ready;
	logic done;
	logic rx_bit;

	modport engine (input cmd, input tx_bit, input valid, output ready, output done,
		output rx_bit);
	modport seq (output cmd, output tx_bit, output valid, input ready, input done,
		input rx_bit);
endinterface : tbbm_bit_if

// *** verilog/tbbm_cfg.svh ***
// Addresses, field positions, reset values and sizes of the two-byte serial bus master
`ifndef TBBM_CFG_SVH
`define TBBM_CFG_SVH

`define TBBM_ADDR_W 16
`define TBBM_DATA_W 8
`define TBBM_OFS_TARGET 16'hff80
`define TBBM_OFS_WR1 16'hff81
`define TBBM_OFS_WR2 16'hff82
`define TBBM_OFS_RD1 16'hff83
`define TBBM_OFS_RD2 16'hff84
`define TBBM_OFS_CSR 16'hff85
`define TBBM_OFS_INT6 16'hff95
`define TBBM_RST_BYTE 8'h00
`define TBBM_BIT_DIR 0
`define TBBM_BIT_LEN 0
`define TBBM_BIT_START 1
`define TBBM_BIT_ACKERR 2
`define TBBM_BIT_IRQ_FLAG 2
`define TBBM_BIT_IRQ_EN 3
`define TBBM_BIT_MSB 7
`define TBBM_BITCNT_W 3
`define TBBM_BITCNT_TOP 3'h7
`define TBBM_BITCNT_ZERO 3'h0
`define TBBM_BITCNT_ONE 3'h1
`define TBBM_SYNC_STAGES 2

`endif

// *** verilog/tbbm_master.sv ***
// Two-byte serial bus master with its processor-visible special-function registers
// What this block does
// RL1: Master only, timed from 400 kHz tick.
// RL2: One or two bytes, single direction.
// RL3: Six registers visible to the processor.
// RL4: Address bits 7..1, direction bit 0.
// RL5: Direction 0 writes, 1 reads.
// RL6: Completion raises interrupt on line six.
// RL7: New transaction drops the completion interrupt.
// RL8: Second byte sent from / stored to second register.
// RL9: Software write sequence, then wait for interrupt.
// RL10: Software read sequence, read bytes afterwards.
// RL11: Start bit reads busy, self-clears at end.
// RL12: Missing acknowledge sets error, start clears it.
// RL13: Length bit one selects two bytes.
// RL14: Flag bit 2, enable bit 3, read clears.
// RL15: Start, address, ack, data, nack last, stop.
`timescale 1ns/100ps
`include "tbbm_cfg.svh"
module tbbm_master #(
	parameter int DATA_W = `TBBM_DATA_W,
	parameter int SYNC_STAGES = `TBBM_SYNC_STAGES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [`TBBM_ADDR_W-1:0] sfr_addr,
	input wire logic [DATA_W-1:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [DATA_W-1:0] sfr_rdata,
	input wire logic tick_400k,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic int6_irq
);
	if (DATA_W != `TBBM_DATA_W || SYNC_STAGES != `TBBM_SYNC_STAGES)
		$error("tbbm_master: only byte-wide registers and two-stage synchronisers");
	tbbm_bit_if bit_bus ();
	logic [DATA_W-1:0] target_address_register, first_write_byte, second_write_byte;
	logic [DATA_W-1:0] first_read_byte, second_read_byte, shifter;
	logic length_select_bit, start_busy_bit, ack_error_bit;
	logic completion_irq_flag, completion_irq_enable;
	tbbm_pkg::tbbm_state_t state, next_state;
	logic [`TBBM_BITCNT_W-1:0] bit_cnt;
	logic byte_idx, waiting, data_sent;
	logic tick_s1, tick_s2, tick_prev, sda_s1, sda_s2;
	logic scl_release, sda_release;

	// Tick and data line come from outside the clock domain
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_s1 <= 1'b0;
			tick_s2 <= 1'b0;
			tick_prev <= 1'b0;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end
		else
		begin
			tick_s1 <= tick_400k;
			tick_s2 <= tick_s1;
			tick_prev <= tick_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
		end
	end

	// Every tick edge is half a bit, so one symbol per tick period
	wire half_edge = tick_s2 ^ tick_prev; // [RL1]

	tbbm_bit_engine u_engine (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.half_edge(half_edge),
		.sda_level(sda_s2),
		.bus(bit_bus),
		.scl_release(scl_release),
		.sda_release(sda_release)
	);

	// Open-drain lines: only ever pulled low, enable low while pulling
	assign scl_out = 1'b0; // [RL1]
	assign scl_oe_n = scl_release;
	assign sda_out = 1'b0;
	assign sda_oe_n = sda_release;

	// Address decode
	wire sel_target = sfr_addr == `TBBM_OFS_TARGET;
	wire sel_wr1 = sfr_addr == `TBBM_OFS_WR1;
	wire sel_wr2 = sfr_addr == `TBBM_OFS_WR2;
	wire sel_rd1 = sfr_addr == `TBBM_OFS_RD1;
	wire sel_rd2 = sfr_addr == `TBBM_OFS_RD2;
	wire sel_csr = sfr_addr == `TBBM_OFS_CSR;
	wire sel_int6 = sfr_addr == `TBBM_OFS_INT6;
	wire idle = state == tbbm_pkg::TBBM_S_IDLE;
	wire cfg_wr = sfr_wr && idle; // [RL11]
	wire go = cfg_wr && sel_csr && sfr_wdata[`TBBM_BIT_START];
	wire read_dir = target_address_register[`TBBM_BIT_DIR]; // [RL5]
	wire last_byte = byte_idx == length_select_bit; // [RL13]
	wire step = bit_bus.done && waiting;
	wire bits_left = bit_cnt != `TBBM_BITCNT_ZERO;
	wire rx_nack = bit_bus.rx_bit; // [RL12]
	wire finish = step && state == tbbm_pkg::TBBM_S_STOP;
	wire int6_read = sfr_rd && sel_int6;
	// After an acknowledge in a write frame, another byte follows unless the last went out
	wire more_bytes = !data_sent || !last_byte;
	logic [DATA_W-1:0] csr_view, int6_view, read_mux;
	always_comb
	begin
		csr_view = `TBBM_RST_BYTE;
		csr_view[`TBBM_BIT_LEN] = length_select_bit;
		csr_view[`TBBM_BIT_START] = start_busy_bit;
		csr_view[`TBBM_BIT_ACKERR] = ack_error_bit;
		int6_view = `TBBM_RST_BYTE;
		int6_view[`TBBM_BIT_IRQ_FLAG] = completion_irq_flag; // [RL14]
		int6_view[`TBBM_BIT_IRQ_EN] = completion_irq_enable;
	end

	// Six transfer registers plus the shared interrupt control register
	assign read_mux = sel_target ? target_address_register // [RL3]
		: sel_wr1 ? first_write_byte
		: sel_wr2 ? second_write_byte
		: sel_rd1 ? first_read_byte
		: sel_rd2 ? second_read_byte
		: sel_csr ? csr_view
		: sel_int6 ? int6_view
		: `TBBM_RST_BYTE;

	// Symbol request for the line engine
	assign bit_bus.valid = !idle && !waiting;
	assign bit_bus.cmd = (state == tbbm_pkg::TBBM_S_START) ? tbbm_pkg::TBBM_CMD_START
		: (state == tbbm_pkg::TBBM_S_STOP) ? tbbm_pkg::TBBM_CMD_STOP
		: (state == tbbm_pkg::TBBM_S_SEND || state == tbbm_pkg::TBBM_S_ACK_TX)
		? tbbm_pkg::TBBM_CMD_WBIT : tbbm_pkg::TBBM_CMD_RBIT;
	// Master acknowledges each read byte but leaves the last one unacknowledged
	assign bit_bus.tx_bit = (state == tbbm_pkg::TBBM_S_ACK_TX) ? last_byte // [RL15]
		: shifter[`TBBM_BIT_MSB];

	always_comb
	begin
		next_state = state;
		case (state)
			tbbm_pkg::TBBM_S_IDLE:
				if (go)
					next_state = tbbm_pkg::TBBM_S_START;
			tbbm_pkg::TBBM_S_START:
				if (step)
					next_state = tbbm_pkg::TBBM_S_SEND;
			tbbm_pkg::TBBM_S_SEND:
				if (step && !bits_left)
					next_state = tbbm_pkg::TBBM_S_ACK_RX;
			tbbm_pkg::TBBM_S_ACK_RX:
				// A missing acknowledge ends the frame early
				if (step)
				begin
					if (rx_nack)
						next_state = tbbm_pkg::TBBM_S_STOP;
					else if (byte_idx == 1'b0 && read_dir)
						next_state = tbbm_pkg::TBBM_S_RECV; // [RL5]
					else if (more_bytes)
						next_state = tbbm_pkg::TBBM_S_SEND;
					else
						next_state = tbbm_pkg::TBBM_S_STOP;
				end
			tbbm_pkg::TBBM_S_RECV:
				if (step && !bits_left)
					next_state = tbbm_pkg::TBBM_S_ACK_TX;
			tbbm_pkg::TBBM_S_ACK_TX:
				if (step)
					next_state = last_byte ? tbbm_pkg::TBBM_S_STOP : tbbm_pkg::TBBM_S_RECV;
			tbbm_pkg::TBBM_S_STOP:
				if (step)
					next_state = tbbm_pkg::TBBM_S_IDLE;
			default:
				next_state = tbbm_pkg::TBBM_S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= tbbm_pkg::TBBM_S_IDLE;
			waiting <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (bit_bus.valid && bit_bus.ready)
				waiting <= 1'b1;
			else if (bit_bus.done)
				waiting <= 1'b0;
		end
	end
	// Shifting, byte selection and captured read data
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			shifter <= `TBBM_RST_BYTE;
			bit_cnt <= `TBBM_BITCNT_TOP;
			byte_idx <= 1'b0;
			data_sent <= 1'b0;
			first_read_byte <= `TBBM_RST_BYTE;
			second_read_byte <= `TBBM_RST_BYTE;
		end
		else if (go)
		begin
			shifter <= target_address_register; // [RL4]
			bit_cnt <= `TBBM_BITCNT_TOP;
			byte_idx <= 1'b0;
			data_sent <= 1'b0;
		end
		else if (step)
		begin
			case (state)
				tbbm_pkg::TBBM_S_SEND:
				begin
					shifter <= {shifter[DATA_W-2:0], 1'b0};
					bit_cnt <= bit_cnt - `TBBM_BITCNT_ONE;
				end
				tbbm_pkg::TBBM_S_ACK_RX:
				begin
					bit_cnt <= `TBBM_BITCNT_TOP;
					// Byte index advances only after a data byte, not the address
					if (data_sent)
						byte_idx <= 1'b1;
					data_sent <= !read_dir;
					shifter <= (data_sent || read_dir) ? second_write_byte // [RL8]
						: first_write_byte; // [RL2]
				end
				tbbm_pkg::TBBM_S_RECV:
				begin
					shifter <= {shifter[DATA_W-2:0], bit_bus.rx_bit};
					bit_cnt <= bit_cnt - `TBBM_BITCNT_ONE;
					if (!bits_left && !byte_idx)
						first_read_byte <= {shifter[DATA_W-2:0], bit_bus.rx_bit};
					if (!bits_left && byte_idx)
						second_read_byte <= {shifter[DATA_W-2:0], bit_bus.rx_bit}; // [RL8]
				end
				tbbm_pkg::TBBM_S_ACK_TX:
				begin
					bit_cnt <= `TBBM_BITCNT_TOP;
					byte_idx <= 1'b1;
				end
				default:
					bit_cnt <= bit_cnt;
			endcase
		end
	end
	// Processor-side registers and status
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			target_address_register <= `TBBM_RST_BYTE;
			first_write_byte <= `TBBM_RST_BYTE;
			second_write_byte <= `TBBM_RST_BYTE;
			length_select_bit <= 1'b0;
			start_busy_bit <= 1'b0;
			ack_error_bit <= 1'b0;
			completion_irq_flag <= 1'b0;
			completion_irq_enable <= 1'b0;
			sfr_rdata <= `TBBM_RST_BYTE;
		end
		else
		begin
			if (sfr_rd)
				sfr_rdata <= read_mux;
			if (cfg_wr && sel_target)
				target_address_register <= sfr_wdata;
			if (cfg_wr && sel_wr1)
				first_write_byte <= sfr_wdata;
			if (cfg_wr && sel_wr2)
				second_write_byte <= sfr_wdata;
			if (cfg_wr && sel_csr)
				length_select_bit <= sfr_wdata[`TBBM_BIT_LEN]; // [RL13]
			if (sfr_wr && sel_int6)
				completion_irq_enable <= sfr_wdata[`TBBM_BIT_IRQ_EN]; // [RL14]
			if (go || finish)
				start_busy_bit <= go; // [RL11]
			if (go || (step && state == tbbm_pkg::TBBM_S_ACK_RX && rx_nack))
				ack_error_bit <= !go; // [RL12]
			// Completion set wins over a read clear in the same cycle
			if (finish || go || int6_read)
				completion_irq_flag <= finish; // [RL6] [RL7] [RL14]
		end
	end
	assign int6_irq = completion_irq_flag && completion_irq_enable; // [RL6]
endmodule : tbbm_master

// *** verilog/tbbm_pkg.sv ***
// Types shared by the two-byte serial bus master modules
package tbbm_pkg;
	typedef enum logic [1:0] {
		TBBM_CMD_START,
		TBBM_CMD_STOP,
		TBBM_CMD_WBIT,
		TBBM_CMD_RBIT
	} tbbm_cmd_t;

	typedef enum logic [2:0] {
		TBBM_S_IDLE,
		TBBM_S_START,
		TBBM_S_SEND,
		TBBM_S_ACK_RX,
		TBBM_S_RECV,
		TBBM_S_ACK_TX,
		TBBM_S_STOP
	} tbbm_state_t;
endpackage : tbbm_pkg
